// ---- logic/dev_ctrl_pkg.sv ----
// Constants for the device control word decoder: command word layout and reset values.
// Assumes a 29-bit command word, most significant bit first, framed by an active-low sync pin.
package dev_ctrl_pkg;

  // Command word size and framing.
  localparam int unsigned WORD_W      = 29;
  localparam logic [4:0]  FRAME_BITS  = 5'h1d;
  localparam logic [4:0]  CNT_MAX     = 5'h1f;

  // Address field of the command word.
  localparam int unsigned RW_BIT      = 28;
  localparam int unsigned CH_SEL_HI   = 27;
  localparam int unsigned CH_SEL_LO   = 24;
  localparam int unsigned TGT_HI      = 23;
  localparam int unsigned TGT_LO      = 22;
  localparam int unsigned ADDR_HI     = 27;
  localparam int unsigned ADDR_LO     = 22;
  localparam logic [5:0]  ADDR_SYS    = 6'h00;

  // Data field of the control word.
  localparam int unsigned CLAMP_HI    = 21;
  localparam int unsigned CLAMP_LO    = 18;
  localparam int unsigned CMP_OE_HI   = 17;
  localparam int unsigned CMP_OE_LO   = 14;
  localparam int unsigned CMP_PWR     = 13;
  localparam int unsigned GND_SEL     = 12;
  localparam int unsigned GUARD_ALM   = 11;
  localparam int unsigned CLAMP_ALM   = 10;
  localparam int unsigned SENSE_SHORT = 9;
  localparam int unsigned GUARD_EN    = 8;
  localparam int unsigned GAIN_HI     = 7;
  localparam int unsigned GAIN_LO     = 6;
  localparam int unsigned TEMP_EN     = 5;
  localparam int unsigned TEMP_TH_HI  = 4;
  localparam int unsigned TEMP_TH_LO  = 3;
  localparam int unsigned LATCHED_ALM = 2;
  localparam int unsigned STORE_HI    = 21;
  localparam int unsigned STORE_LO    = 2;
  localparam int unsigned STORE_W     = 20;

  // Power-on values of the stored fields.
  localparam logic [3:0]  CLAMP_RESET = 4'h0;
  localparam logic [15:0] MISC_RESET  = 16'h0000;
  localparam logic [3:0]  NIBBLE_ZERO = 4'h0;

endpackage

// ---- logic/serial_word_rx.sv ----
// Serial command receiver: collects one command word per sync frame.
// Assumes pins from outside the core clock domain; sclk is much slower than core_clk.
`timescale 1ns/1ns
module serial_word_rx
  import dev_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Serial pins.
  input  wire logic              sclk_pin,
  input  wire logic              sync_n_pin,
  input  wire logic              sdi_pin,
  // Received word.
  output logic                   word_valid,
  output logic [WORD_W-1:0]      word_data
);

  logic [2:0]        sclk_sync_reg;
  logic [2:0]        sync_n_sync_reg;
  logic [1:0]        sdi_sync_reg;
  logic [4:0]        cnt_reg;
  logic [4:0]        cnt_next;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic              valid_reg;
  logic              valid_next;
  logic [WORD_W-1:0] data_reg;
  logic [WORD_W-1:0] data_next;
  logic              sclk_rise;
  logic              frame_start;
  logic              frame_end;
  logic              in_frame;

  // Two stages before use; the third stage only serves the edge detectors.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_sync_reg   <= 3'h0;
      sync_n_sync_reg <= 3'h7;
      sdi_sync_reg    <= 2'h0;
    end else begin
      sclk_sync_reg   <= {sclk_sync_reg[1:0], sclk_pin};
      sync_n_sync_reg <= {sync_n_sync_reg[1:0], sync_n_pin};
      sdi_sync_reg    <= {sdi_sync_reg[0], sdi_pin};
    end
  end

  assign sclk_rise   = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign frame_start = ~sync_n_sync_reg[1] & sync_n_sync_reg[2];
  assign frame_end   = sync_n_sync_reg[1] & ~sync_n_sync_reg[2];
  assign in_frame    = ~sync_n_sync_reg[1];

  // Shift bits in while sync is low; a word is offered only if exactly one word arrived.
  always_comb begin
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    valid_next = 1'b0;
    data_next  = data_reg;
    if (frame_start) begin
      cnt_next = 5'h00;
    end else if (in_frame && sclk_rise) begin
      shift_next = {shift_reg[WORD_W-2:0], sdi_sync_reg[1]};
      if (cnt_reg != CNT_MAX) begin
        cnt_next = cnt_reg + 5'h01;
      end
    end
    if (frame_end && cnt_reg == FRAME_BITS) begin
      valid_next = 1'b1;
      data_next  = shift_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg   <= 5'h00;
      shift_reg <= '0;
      valid_reg <= 1'b0;
      data_reg  <= '0;
    end else begin
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      valid_reg <= valid_next;
      data_reg  <= data_next;
    end
  end

  assign word_valid = valid_reg;
  assign word_data  = data_reg;

endmodule

// ---- logic/system_control_word_decode.sv ----
// Device control word decoder: stores the device-wide control word and forwards other commands.
// Assumes the serial pins come from the host and per-channel clamp writes from core_clk logic.
//
// Behaviour
// - A command reaches the control word only when channel-select and target bits are all zero.
// - One control word serves the whole device, not one per channel.
// - Bit 28 is read/write, 27..24 channel select, 23..22 target, 21..18 clamps, 17..15 cmp oe.
// - Bit 14 cmp oe 0, 13 cmp power, 12 ground sel, 11..2 alarms, sense, guard, gain, temp.
// - The two lowest bits of a write are unused and nothing is stored from them.
// - A low read/write bit writes the data bits into the addressed register.
// - A high read/write bit starts a readback of the addressed register.
// - Each clamp enable bit turns its channel clamp on when one and off when zero.
// - Per-channel register writes and control word writes share one clamp enable state.
// - Readback of either path reports the clamp enable most recently written.
// - Comparator outputs stay high-Z after power-on until their output enable is set.
// - An enabled comparator output drives comparator data while comparator power is on, and drives low while it is off.
// - Comparator power resets to zero and follows the written bit.
// - Guard enable resets to zero and a one enables the guard amplifier.
`timescale 1ns/1ns
module system_control_word_decode
  import dev_ctrl_pkg::*;
#(
  parameter int unsigned N_CH = 4
)
(
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Serial command pins.
  input  wire logic              sclk_pin,
  input  wire logic              sync_n_pin,
  input  wire logic              sdi_pin,
  // Clamp enable writes from the per-channel registers.
  input  wire logic [N_CH-1:0]   chan_clamp_wr,
  input  wire logic [N_CH-1:0]   chan_clamp_val,
  // Raw comparator results and comparator output pins.
  input  wire logic [N_CH-1:0]   cmp_result_pin,
  output logic [N_CH-1:0]        cmp_out_o,
  output logic [N_CH-1:0]        cmp_out_oe,
  // Settings towards the analogue blocks.
  output logic [N_CH-1:0]        clamp_en,
  output logic                   cmp_power_en,
  output logic                   per_channel_ground_sel,
  output logic                   guard_alarm_en,
  output logic                   clamp_alarm_en,
  output logic                   internal_sense_short,
  output logic                   guard_en,
  output logic [1:0]             meas_gain,
  output logic                   temp_en,
  output logic [1:0]             temp_threshold,
  output logic                   latched_alarm,
  // Readback of the control word.
  output logic                   readback_valid,
  output logic [WORD_W-1:0]      readback_word,
  // Commands for other register banks.
  output logic                   other_wr_valid,
  output logic                   other_rd_valid,
  output logic [WORD_W-1:0]      other_word
);

  // True when the address bits select the device control word.
  function automatic logic is_sys_ctrl(input logic [WORD_W-1:0] w);
    is_sys_ctrl = (w[ADDR_HI:ADDR_LO] == ADDR_SYS);
  endfunction

  logic              word_valid;
  logic [WORD_W-1:0] word_data;
  logic              cmd_rd;
  logic              cmd_sys;

  logic [N_CH-1:0]   clamp_reg;
  logic [N_CH-1:0]   clamp_next;
  logic [15:0]       misc_reg;
  logic [15:0]       misc_next;
  logic              rb_valid_reg;
  logic              rb_valid_next;
  logic [WORD_W-1:0] rb_word_reg;
  logic [WORD_W-1:0] rb_word_next;
  logic              owr_reg;
  logic              owr_next;
  logic              ord_reg;
  logic              ord_next;
  logic [WORD_W-1:0] oword_reg;
  logic [WORD_W-1:0] oword_next;
  logic [N_CH-1:0]   cmp_meta_reg;
  logic [N_CH-1:0]   cmp_sync_reg;
  logic [N_CH-1:0]   cmp_o_reg;
  logic [N_CH-1:0]   cmp_o_next;
  logic [STORE_W-1:0] stored_view;

  // Serial frame collection.
  serial_word_rx u_rx (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .sclk_pin   (sclk_pin),
    .sync_n_pin (sync_n_pin),
    .sdi_pin    (sdi_pin),
    .word_valid (word_valid),
    .word_data  (word_data)
  );

  assign cmd_rd  = word_data[RW_BIT];
  assign cmd_sys = is_sys_ctrl(word_data);

  // Misc field order: cmp oe[15:12], power, gnd, guard alm, clamp alm, sense, guard, gain,
  // temp en, temp threshold, latched alarm.
  assign stored_view = {clamp_reg, misc_reg};

  // Control word update; only bits 21 down to 2 are kept, bits 1 and 0 are dropped.
  always_comb begin
    clamp_next = clamp_reg;
    misc_next  = misc_reg;
    if (word_valid && !cmd_rd && cmd_sys) begin
      clamp_next = word_data[CLAMP_HI:CLAMP_LO];
      misc_next  = word_data[CMP_OE_HI:STORE_LO];
    end
    // A per-channel write after a control word write in the same cycle wins for its channel.
    for (int i = 0; i < N_CH; i++) begin
      if (chan_clamp_wr[i]) begin
        clamp_next[i] = chan_clamp_val[i];
      end
    end
  end

  // One device-wide copy of the control word.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clamp_reg <= CLAMP_RESET;
      misc_reg  <= MISC_RESET;
    end else begin
      clamp_reg <= clamp_next;
      misc_reg  <= misc_next;
    end
  end

  // Readback of the control word and forwarding of all other commands.
  always_comb begin
    rb_valid_next = 1'b0;
    rb_word_next  = rb_word_reg;
    owr_next      = 1'b0;
    ord_next      = 1'b0;
    oword_next    = oword_reg;
    if (word_valid) begin
      if (cmd_rd && cmd_sys) begin
        rb_valid_next = 1'b1;
        rb_word_next  = {word_data[RW_BIT:ADDR_LO], stored_view, 2'h0};
      end else if (cmd_rd) begin
        ord_next   = 1'b1;
        oword_next = word_data;
      end else if (!cmd_sys) begin
        owr_next   = 1'b1;
        oword_next = word_data;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rb_valid_reg <= 1'b0;
      rb_word_reg  <= '0;
      owr_reg      <= 1'b0;
      ord_reg      <= 1'b0;
      oword_reg    <= '0;
    end else begin
      rb_valid_reg <= rb_valid_next;
      rb_word_reg  <= rb_word_next;
      owr_reg      <= owr_next;
      ord_reg      <= ord_next;
      oword_reg    <= oword_next;
    end
  end

  // Comparator results come from the analogue side and are synchronised first.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_meta_reg <= NIBBLE_ZERO;
      cmp_sync_reg <= NIBBLE_ZERO;
    end else begin
      cmp_meta_reg <= cmp_result_pin;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // A powered-down comparator holds its output low even if the pin is enabled.
  always_comb begin
    cmp_o_next = cmp_sync_reg & {N_CH{misc_reg[CMP_PWR-STORE_LO]}};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_o_reg <= NIBBLE_ZERO;
    end else begin
      cmp_o_reg <= cmp_o_next;
    end
  end

  // Output pins and settings, all taken from registers.
  assign cmp_out_o              = cmp_o_reg;
  assign cmp_out_oe             = misc_reg[CMP_OE_HI-STORE_LO:CMP_OE_LO-STORE_LO];
  assign clamp_en               = clamp_reg;
  assign cmp_power_en           = misc_reg[CMP_PWR-STORE_LO];
  assign per_channel_ground_sel = misc_reg[GND_SEL-STORE_LO];
  assign guard_alarm_en         = misc_reg[GUARD_ALM-STORE_LO];
  assign clamp_alarm_en         = misc_reg[CLAMP_ALM-STORE_LO];
  assign internal_sense_short   = misc_reg[SENSE_SHORT-STORE_LO];
  assign guard_en               = misc_reg[GUARD_EN-STORE_LO];
  assign meas_gain              = misc_reg[GAIN_HI-STORE_LO:GAIN_LO-STORE_LO];
  assign temp_en                = misc_reg[TEMP_EN-STORE_LO];
  assign temp_threshold         = misc_reg[TEMP_TH_HI-STORE_LO:TEMP_TH_LO-STORE_LO];
  assign latched_alarm          = misc_reg[LATCHED_ALM-STORE_LO];
  assign readback_valid         = rb_valid_reg;
  assign readback_word          = rb_word_reg;
  assign other_wr_valid         = owr_reg;
  assign other_rd_valid         = ord_reg;
  assign other_word             = oword_reg;

endmodule

// ---- tb/system_control_word_decode_asserts.sv ----
// Checker for the device control word decoder, seeing only its top-level ports.
// Assumes one core_clk domain with asynchronous active-low rstn.
`timescale 1ns/1ns
module system_control_word_decode_asserts
  import dev_ctrl_pkg::*;
#(parameter int unsigned N_CH = 4)
(
  // Inputs of the decoder.
  input wire logic core_clk, rstn, sclk_pin, sync_n_pin, sdi_pin,
  input wire logic [N_CH-1:0] chan_clamp_wr, chan_clamp_val, cmp_result_pin,
  // Outputs of the decoder.
  input wire logic [N_CH-1:0] cmp_out_o, cmp_out_oe, clamp_en,
  input wire logic cmp_power_en, per_channel_ground_sel, guard_alarm_en, clamp_alarm_en,
  input wire logic internal_sense_short, guard_en, temp_en, latched_alarm,
  input wire logic [1:0] meas_gain, temp_threshold,
  input wire logic readback_valid, other_wr_valid, other_rd_valid,
  input wire logic [WORD_W-1:0] readback_word, other_word
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // A readback strobe lasts exactly one cycle.
  sequence rb_pulse_s;
    readback_valid ##1 !readback_valid;
  endsequence
  reset_clear_a: assert property ($rose(rstn) |-> !cmp_out_oe && !cmp_power_en && !guard_en)
    else $error("Settings not cleared after reset.");
  chan_clamp_a: assert property (|chan_clamp_wr |=>
    ((clamp_en ^ $past(chan_clamp_val)) & $past(chan_clamp_wr)) == '0)
    else $error("Clamp enable missed a per-channel write.");
  cmp_dead_a: assert property (!cmp_power_en && !$past(cmp_power_en) |-> cmp_out_o == '0)
    else $error("Comparator data passed while powered down.");
  rb_pulse_a: assert property (readback_valid |-> rb_pulse_s)
    else $error("Readback strobe longer than one cycle.");
  rb_format_a: assert property (readback_valid |-> readback_word[28:22] == 7'h40
    && readback_word[1:0] == 2'b00) else $error("Readback header or unused bits wrong.");
  rb_mirror_a: assert property (readback_valid |-> readback_word[21:2] == {clamp_en,
    cmp_out_oe, cmp_power_en, per_channel_ground_sel, guard_alarm_en, clamp_alarm_en,
    internal_sense_short, guard_en, meas_gain, temp_en, temp_threshold, latched_alarm})
    else $error("Readback does not match the stored settings.");
  settle_a: assert property ($changed({guard_en, cmp_power_en, cmp_out_oe})
    |-> $past(sync_n_pin, 4)) else $error("Settings changed inside a frame.");
  fwd_wr_a: assert property (other_wr_valid |-> !other_word[28]
    && other_word[27:22] != 6'h00 && !readback_valid) else $error("Bad forwarded write.");
  fwd_rd_a: assert property (other_rd_valid |-> other_word[28]
    && other_word[27:22] != 6'h00 && !other_wr_valid) else $error("Bad forwarded read.");
endmodule

// ---- tb/host_serial_model.sv ----
// Host model: drives command words onto the serial pins of the decoder.
// Assumes the bench calls send; pins move only at core_clk falling edges.
`timescale 1ns/1ns
module host_serial_model (
  // Pacing clock.
  input wire logic core_clk,
  // Serial pins towards the device.
  output logic     sclk_pin,
  output logic     sync_n_pin,
  output logic     sdi_pin
);
  // Pins start idle: clock low, no frame.
  initial begin
    sclk_pin = 1'b0;
    sync_n_pin = 1'b1;
    sdi_pin = 1'b0;
  end
  // Sends the top nbits of w, with bits 1..0 cleared for writes, most significant first; half an sclk period is 4 cycles.
  task automatic send(input logic [28:0] w, input int nbits);
    logic [28:0] d;
    d = w;
    if (!d[28]) d[1:0] = 2'b00;
    @(negedge core_clk);
    sync_n_pin = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int i = 28; i > 28 - nbits; i--) begin
      sdi_pin = d[i];
      repeat (4) @(negedge core_clk);
      sclk_pin = 1'b1;
      repeat (4) @(negedge core_clk);
      sclk_pin = 1'b0;
    end
    repeat (4) @(negedge core_clk);
    sync_n_pin = 1'b1;
    // A released data line must not look like a held bit.
    sdi_pin = ~sdi_pin;
    repeat (12) @(negedge core_clk);
  endtask
endmodule

// ---- tb/system_control_word_decode_tb.sv ----
// Self-checking bench for the device control word decoder.
// Assumes the host model and the checker in tb/; core_clk at 10 MHz.
`timescale 1ns/1ns
module system_control_word_decode_tb;
  import dev_ctrl_pkg::*;
  localparam int unsigned N_CH = 4;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic sclk_pin, sync_n_pin, sdi_pin;
  logic [N_CH-1:0] chan_clamp_wr = '0, chan_clamp_val = '0, cmp_result_pin = '0;
  logic [N_CH-1:0] cmp_out_o, cmp_out_oe, clamp_en;
  logic cmp_power_en, per_channel_ground_sel, guard_alarm_en, clamp_alarm_en;
  logic internal_sense_short, guard_en, temp_en, latched_alarm;
  logic [1:0] meas_gain, temp_threshold;
  logic readback_valid, other_wr_valid, other_rd_valid;
  logic [WORD_W-1:0] readback_word, other_word, last_fwd, w;
  logic [19:0] settings, stored;
  int err_count = 0, compares = 0, rb_cnt = 0, wr_cnt = 0, rd_cnt = 0;
  assign settings = {clamp_en, cmp_out_oe, cmp_power_en, per_channel_ground_sel, guard_alarm_en,
    clamp_alarm_en, internal_sense_short, guard_en, meas_gain, temp_en, temp_threshold,
    latched_alarm};
  always #50 core_clk = ~core_clk;
  system_control_word_decode #(.N_CH(N_CH)) system_control_word_decode_i (.*);
  host_serial_model host_serial_model_i (.*);
  // Counts strobes and keeps the last forwarded word.
  always @(posedge core_clk) begin
    if (readback_valid === 1'b1) rb_cnt++;
    if (other_wr_valid === 1'b1) wr_cnt++;
    if (other_rd_valid === 1'b1) rd_cnt++;
    if ((other_wr_valid | other_rd_valid) === 1'b1) last_fwd = other_word;
  end
  // Stored fields of a system write are its data bits above the two unused ones.
  function automatic logic [19:0] exp_set(input logic [28:0] cmd);
    return cmd[21:2];
  endfunction
  function automatic logic [28:0] exp_rb(input logic [19:0] s);
    return {7'h40, s, 2'b00};
  endfunction
  task automatic chk(input logic [28:0] got, input logic [28:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic frame(input logic [28:0] cw, input int n);
    rb_cnt = 0;
    wr_cnt = 0;
    rd_cnt = 0;
    host_serial_model_i.send(cw, n);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #2_000_000;
    err_count++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    wrap_up();
  end
  // Main sequence.
  initial begin
    w = 29'($urandom(8329));
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk(29'(settings), '0, "reset");
    $display("reset test done");
    // System writes (all ones first), each read back.
    for (int k = 0; k < 6; k++) begin
      w = {7'h00, (k == 0) ? 22'h3f_fffc : 22'($urandom()) & 22'h3f_fffc};
      frame(w, 29);
      chk(29'(settings), 29'(exp_set(w)), "fields");
      frame(29'h1000_0000, 29);
      chk(29'(rb_cnt), 29'd1, "rb count");
      chk(readback_word, exp_rb(exp_set(w)), "rb word");
      stored = exp_set(w);
      $display("write/read %0d done", k);
    end
    // Per-channel clamp writes share the clamp state.
    // Written channels always flip, so a lost per-channel write cannot hide.
    chan_clamp_val = (4'($urandom()) & 4'ha) | (~stored[19:16] & 4'h5);
    chan_clamp_wr = 4'h5;
    @(negedge core_clk);
    chan_clamp_wr = 4'h0;
    stored[19:16] = (stored[19:16] & 4'ha) | (chan_clamp_val & 4'h5);
    chk(29'(clamp_en), 29'(stored[19:16]), "clamp direct");
    frame(29'h1000_0000, 29);
    chk(readback_word, exp_rb(stored), "clamp mirror");
    $display("clamp test done");
    // Foreign addresses are forwarded and leave the control word alone.
    for (int k = 0; k < 3; k++) begin
      w = {1'(k == 1), 6'd1 + 6'($urandom_range(62)), 22'($urandom())};
      if (!w[28]) w[1:0] = 2'b00;
      frame(w, 29);
      chk(29'(settings), 29'(stored), "foreign");
      chk(29'(wr_cnt * 2 + rd_cnt), (k == 1) ? 29'd1 : 29'd2, "fwd kind");
      chk(last_fwd, w, "fwd word");
    end
    // A frame one bit short is dropped.
    frame({7'h00, ~stored, 2'b00}, 28);
    chk(29'(settings), 29'(stored), "short");
    chk(29'(rb_cnt + wr_cnt + rd_cnt), 29'd0, "short strobes");
    $display("address test done");
    // Comparator data passes only while comparator power is on.
    for (int p = 0; p < 2; p++) begin
      frame({7'h00, 4'h0, 4'hf, 1'(p), 13'h0000}, 29);
      // At least one result bit is high, so a leak while powered down shows.
      cmp_result_pin = 4'($urandom()) | 4'h1;
      repeat (5) @(negedge core_clk);
      chk(29'(cmp_out_o), 29'(p ? cmp_result_pin : 4'h0), "cmp out");
      chk(29'(cmp_out_oe), 29'h0f, "cmp oe");
    end
    $display("comparator test done");
    wrap_up();
  end
endmodule
bind system_control_word_decode system_control_word_decode_asserts #(.N_CH(N_CH))
  system_control_word_decode_asserts_i (.*);
